// File: src/wdg_update_status.sv
// independent watchdog: key unlock, config transfer tracking, down-counter
`timescale 1ns/1ps
`include "wdg_defs.svh"
module wdg_update_status
   import wdg_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   input  wire logic        LOW_SPEED_OSC,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   output logic             WDG_IRQ,
   output logic             WDG_RESET
);
   // oscillator sampling
   logic         osc_meta_ff;
   logic         osc_sync_ff;
   logic         osc_prev_ff;
   // bus and control state
   logic [31:0]  rdata_ff;
   logic         unlock_ff;
   logic         irq_sel_ff;
   logic         irq_ff;
   logic         rst_out_ff;
   wd_state_type state_ff;
   wd_state_type nxt_state;
   logic [11:0]  cnt_ff;
   logic [7:0]   ps_ff;
   // per-field transfer tracking, 0 prescaler, 1 reload, 2 threshold
   field_type    fld_shadow [3];
   field_type    fld_active [3];
   logic [2:0]   fld_pending;
   logic [2:0]   fld_wr;

   // address decode and key commands
   wire          osc_tick   = osc_sync_ff & ~osc_prev_ff;
   wire          sel_key    = (ADDR == `OFS_KEY);
   wire          sel_presc  = (ADDR == `OFS_PRESCALER);
   wire          sel_reload = (ADDR == `OFS_RELOAD);
   wire          sel_status = (ADDR == `OFS_STATUS);
   wire          sel_ctrl   = (ADDR == `OFS_CONTROL);
   wire          sel_thresh = (ADDR == `OFS_THRESHOLD);
   // status has no write path at all, so software never touches the flags
   wire          wr_key     = WR & sel_key;
   wire [15:0]   key        = WDATA[15:0];
   wire          key_feed   = wr_key & (key == `KEY_FEED);
   wire          key_unlock = wr_key & (key == `KEY_UNLOCK);
   wire          key_start  = wr_key & (key == `KEY_START);
   wire          wr_ctrl    = WR & sel_ctrl;
   wire          wr_presc   = WR & unlock_ff & sel_presc;
   wire          wr_reload  = WR & unlock_ff & sel_reload;
   wire          wr_thresh  = WR & unlock_ff & sel_thresh;
   wire          wr_irq_sel = wr_ctrl & unlock_ff;
   wire          irq_clr    = wr_ctrl & WDATA[`CR_IRQ_CLR_BIT];
   wire [11:0]   wdata12    = WDATA[11:0];
   wire [11:0]   wdata_pr   = {9'h000, WDATA[2:0]};

   assign fld_wr = {wr_thresh, wr_reload, wr_presc};

   // one tracker per protected field
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_fld
         localparam field_type RV = (g == 0) ? `RST_PRESCALER :
                                    (g == 1) ? `RST_RELOAD : `RST_THRESHOLD;
         wdg_xfer_track #(.RST_VAL(RV)) u_track (
            .clk     (REF_CLK),
            .srst    (SRST),
            .wr      (fld_wr[g]),
            .wdata   ((g == 0) ? wdata_pr : wdata12),
            .tick    (osc_tick),
            .shadow  (fld_shadow[g]),
            .active  (fld_active[g]),
            .pending (fld_pending[g])
         );
      end
   endgenerate

   // prescaler divide: 4 << sel, saturating at 256
   wire [2:0]    psel     = fld_active[0][2:0];
   wire [2:0]    psel_sat = (psel > 3'h6) ? 3'h6 : psel;
   wire [8:0]    div      = 9'h004 << psel_sat;
   wire [7:0]    ps_last  = 8'(div - 9'h001);
   wire          running  = (state_ff == WD_RUN);
   // at-or-past the last count, so a smaller divider chosen mid-period cannot wrap
   wire          dec      = running & osc_tick & (ps_ff >= ps_last);
   wire [11:0]   cnt_dec  = cnt_ff - 12'h001;
   wire          hit_thr  = dec & (cnt_dec == fld_active[2]);
   wire          hit_zero = dec & (cnt_dec == 12'h000);
   wire          refill   = key_feed | (hit_zero & irq_sel_ff);

   // read mux; status bits come only from the trackers, rest read zero
   wire [31:0]   status_w = {29'h0, fld_pending[2], fld_pending[1], fld_pending[0]};
   wire [31:0]   rd_mux   =
      sel_presc  ? {20'h0, fld_shadow[0]} :
      sel_reload ? {20'h0, fld_shadow[1]} :
      sel_status ? status_w :
      sel_ctrl   ? {31'h0, irq_sel_ff} :
      sel_thresh ? {20'h0, fld_shadow[2]} : 32'h0;

   // next watchdog state; a feed on the very cycle of zero wins over expiry
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         WD_IDLE: begin
            if (key_start) begin
               nxt_state = WD_RUN;
            end
         end
         WD_RUN: begin
            if (hit_zero && !irq_sel_ff && !key_feed) begin
               nxt_state = WD_EXPIRED;
            end
         end
         WD_EXPIRED: nxt_state = WD_EXPIRED;
         default:    nxt_state = WD_IDLE;
      endcase
   end

   // two flops on the free-running oscillator pin before any logic reads it
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         osc_meta_ff <= 1'b0;
         osc_sync_ff <= 1'b0;
      end else begin
         osc_meta_ff <= LOW_SPEED_OSC;
         osc_sync_ff <= osc_meta_ff;
      end
   end

   // last synced level for edge detection; only the second flop feeds it
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         osc_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff <= osc_sync_ff;
      end
   end

   // any key other than unlock closes the protection again
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         unlock_ff <= 1'b0;
      end else if (wr_key) begin
         unlock_ff <= key_unlock;
      end
   end

   // overflow action select, writable only while unlocked
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         irq_sel_ff <= 1'b0;
      end else if (wr_irq_sel) begin
         irq_sel_ff <= WDATA[`CR_IRQ_SEL_BIT];
      end
   end

   // read data stands one cycle, zero otherwise, so no stale word lingers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdata_ff <= 32'h0;
      end else begin
         rdata_ff <= RD ? rd_mux : 32'h0;
      end
   end

   // watchdog state register
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_ff <= WD_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // down-counter; feeding takes the transferred reload value, not the shadow
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cnt_ff <= `RST_RELOAD;
      end else if (refill) begin
         cnt_ff <= fld_active[1];
      end else if (dec) begin
         cnt_ff <= cnt_dec;
      end
   end

   // prescaler count restarts on every refill so a feed buys a full period
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ps_ff <= 8'h00;
      end else if (refill || dec) begin
         ps_ff <= 8'h00;
      end else if (running && osc_tick) begin
         ps_ff <= ps_ff + 8'h01;
      end
   end

   // interrupt flag: a new event wins over a clear in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         irq_ff <= 1'b0;
      end else if (hit_thr || (hit_zero && irq_sel_ff)) begin
         irq_ff <= 1'b1;
      end else if (irq_clr) begin
         irq_ff <= 1'b0;
      end
   end

   // reset request holds until the next system reset
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rst_out_ff <= 1'b0;
      end else begin
         rst_out_ff <= (nxt_state == WD_EXPIRED);
      end
   end

   assign RDATA     = rdata_ff;
   assign WDG_IRQ   = irq_ff;
   assign WDG_RESET = rst_out_ff;
endmodule : wdg_update_status

// File: src/wdg_defs.svh
// register offsets, field positions, reset values and timing counts for the watchdog
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

`define OFS_KEY        8'h00
`define OFS_PRESCALER  8'h04
`define OFS_RELOAD     8'h08
`define OFS_STATUS     8'h0C
`define OFS_CONTROL    8'h10
`define OFS_THRESHOLD  8'h14

`define KEY_FEED       16'hAAAA
`define KEY_UNLOCK     16'h5555
`define KEY_START      16'hCCCC

`define ST_PRESC_BIT   0
`define ST_RELOAD_BIT  1
`define ST_THRESH_BIT  2
`define CR_IRQ_SEL_BIT 0
`define CR_IRQ_CLR_BIT 1

`define RST_PRESCALER  12'h000
`define RST_RELOAD     12'hFFF
`define RST_THRESHOLD  12'hFFF

// oscillator edges a transfer takes; limit is 5
`define XFER_TICKS     3'h3
`define XFER_LIMIT     3'h5

`endif

// File: src/wdg_pkg.sv
// types shared by the watchdog design
package wdg_pkg;
   typedef enum logic [2:0] {
      WD_IDLE    = 3'b001,
      WD_RUN     = 3'b010,
      WD_EXPIRED = 3'b100
   } wd_state_type;
   typedef logic [11:0] field_type;
endpackage : wdg_pkg

// File: src/wdg_xfer_track.sv
// one configuration field moving into the oscillator-counted domain
`timescale 1ns/1ps
`include "wdg_defs.svh"
module wdg_xfer_track
   import wdg_pkg::*;
#(
   parameter field_type RST_VAL = 12'h000
) (
   input  wire logic      clk,
   input  wire logic      srst,
   input  wire logic      wr,
   input  wire field_type wdata,
   input  wire logic      tick,
   output field_type      shadow,
   output field_type      active,
   output logic           pending
);
   field_type  shadow_ff;
   field_type  active_ff;
   logic       pend_ff;
   logic [2:0] cnt_ff;
   wire        done = pend_ff & tick & (cnt_ff == `XFER_TICKS - 3'h1);

   // a new write restarts the count so the newest value always lands
   always_ff @(posedge clk) begin
      if (srst) begin
         shadow_ff <= RST_VAL;
         active_ff <= RST_VAL;
         pend_ff   <= 1'b0;
         cnt_ff    <= 3'h0;
      end else if (wr) begin
         shadow_ff <= wdata;
         pend_ff   <= 1'b1;
         cnt_ff    <= 3'h0;
      end else if (done) begin
         active_ff <= shadow_ff;
         pend_ff   <= 1'b0;
         cnt_ff    <= 3'h0;
      end else if (pend_ff && tick) begin
         cnt_ff    <= cnt_ff + 3'h1;
      end
   end

   assign shadow  = shadow_ff;
   assign active  = active_ff;
   assign pending = pend_ff;
endmodule : wdg_xfer_track

// File: dv/wdg_update_status_chk.sv
// checker: pending-flag timing and read data at the watchdog ports
`timescale 1ns/1ps
module wdg_update_status_chk (
   input wire logic        REF_CLK,
   input wire logic        SRST,
   input wire logic        LOW_SPEED_OSC,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        WDG_IRQ,
   input wire logic        WDG_RESET
);
   logic       unl_ff;
   logic       osc_ff;
   logic [3:0] tk_ff [3];
   wire  [2:0] hit   = {ADDR == 8'h14, ADDR == 8'h08, ADDR == 8'h04} & {3{WR & unl_ff}};
   wire        st_rd = RD && ADDR == 8'h0C;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // pin edges since each field write; counts raw pin, design lags a few clocks
   always_ff @(posedge REF_CLK) begin
      osc_ff <= LOW_SPEED_OSC;
      if (SRST) unl_ff <= 1'b0;
      else if (WR && ADDR == 8'h00) unl_ff <= WDATA[15:0] == 16'h5555;
      for (int i = 0; i < 3; i++) begin
         if (SRST) tk_ff[i] <= 4'hF;
         else if (hit[i]) tk_ff[i] <= 4'h0;
         else if (LOW_SPEED_OSC && !osc_ff && tk_ff[i] != 4'hF) tk_ff[i] <= tk_ff[i] + 4'h1;
      end
   end
   AST_PRESC_SET: assert property (hit[0] ##1 st_rd |=> RDATA[0])
      else $error("prescaler pending not set");
   AST_RELOAD_SET: assert property (hit[1] ##1 st_rd |=> RDATA[1])
      else $error("reload pending not set");
   AST_THRESH_SET: assert property (hit[2] ##1 st_rd |=> RDATA[2])
      else $error("threshold pending not set");
   AST_PRESC_CLR: assert property (st_rd && tk_ff[0] > 4'h5 |=> !RDATA[0])
      else $error("prescaler pending stuck");
   AST_RELOAD_CLR: assert property (st_rd && tk_ff[1] > 4'h5 |=> !RDATA[1])
      else $error("reload pending stuck");
   AST_THRESH_CLR: assert property (st_rd && tk_ff[2] > 4'h5 |=> !RDATA[2])
      else $error("threshold pending stuck");
   AST_ST_RSV: assert property (st_rd |=> RDATA[31:3] == 29'h0)
      else $error("status reserved bits set");
   AST_RD_IDLE: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data outside read cycle");
   cover property (hit[1]);
   cover property ($rose(WDG_IRQ));
   cover property (st_rd ##1 RDATA[2]);
   cover property ($rose(WDG_RESET));
endmodule : wdg_update_status_chk

// File: dv/watchdog_update_status_tb.sv
// self-checking bench for watchdog pending flags, key protection and counter
`timescale 1ns/1ps
`include "wdg_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module watchdog_update_status_tb;
   typedef struct packed {logic [7:0] a; logic [31:0] d, e, st;} row_type;
   logic        clk = 1'b0, srst = 1'b1, osc = 1'b0, wr = 1'b0, rd = 1'b0, irq, wrst;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  oc = 4'h0;
   int          bad_count = 0, compares = 0;
   row_type     rows [4] = '{'{8'h04, 32'hFFFF_FFFD, 32'h5, 32'h1},
      '{8'h08, 32'hFFFF_F004, 32'h4, 32'h2}, '{8'h14, 32'h2, 32'h2, 32'h4},
      '{8'h04, 32'h0, 32'h0, 32'h1}};
   wdg_update_status dut (.REF_CLK(clk), .SRST(srst), .LOW_SPEED_OSC(osc), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .WDG_IRQ(irq), .WDG_RESET(wrst));
   initial forever #5 clk = ~clk;
   // slow oscillator, 16 clocks a period, well under the clk/4 limit
   always @(posedge clk) begin
      oc <= oc + 4'h1;
      osc <= oc[3];
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(n, e, rdata)
   endtask : rd_chk
   // write then status read with no gap, so the flag is seen at its first cycle
   task automatic wr_then_status(input string n, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= `OFS_STATUS;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(n, e, rdata)
   endtask : wr_then_status
   // reset for three edges, return just after the first edge past release
   task automatic pulse_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse_reset
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200us;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(`OFS_KEY, 32'h5555);
         wr_then_status("pending set", rows[i].a, rows[i].d, rows[i].st);
         repeat (112) @(posedge clk);
         rd_chk("pending clear", `OFS_STATUS, 32'h0);
         rd_chk("field", rows[i].a, rows[i].e);
         $display("test row %0d done", i);
      end
      wr_reg(`OFS_KEY, 32'h0);
      wr_reg(`OFS_RELOAD, 32'h777);
      rd_chk("locked status", `OFS_STATUS, 32'h0);
      rd_chk("locked reload", `OFS_RELOAD, 32'h4);
      wr_reg(`OFS_STATUS, 32'hFFFF_FFFF);
      rd_chk("status write", `OFS_STATUS, 32'h0);
      $display("test protection done");
      wr_reg(`OFS_KEY, 32'h5555);
      wr_reg(`OFS_CONTROL, 32'h1);
      wr_reg(`OFS_KEY, 32'hCCCC);
      wr_reg(`OFS_KEY, 32'hAAAA);
      repeat (96) @(posedge clk);
      #1;
      `CHK("irq early", 1'b0, irq)
      repeat (64) @(posedge clk);
      #1;
      `CHK("irq at threshold", 1'b1, irq)
      wr_reg(`OFS_CONTROL, 32'h2);
      wr_reg(`OFS_KEY, 32'hAAAA);
      repeat (96) @(posedge clk);
      #1;
      `CHK("irq after feed", 1'b0, irq)
      repeat (64) @(posedge clk);
      #1;
      `CHK("irq refed", 1'b1, irq)
      `CHK("no reset in irq mode", 1'b0, wrst)
      $display("test counter done");
      // mid-run reset, then overflow with the reset action selected
      pulse_reset();
      `CHK("reset irq", 1'b0, irq)
      `CHK("reset rdata", 32'h0, rdata)
      rd_chk("reset reload", `OFS_RELOAD, `RST_RELOAD);
      wr_reg(`OFS_KEY, 32'h5555);
      wr_then_status("reload pending", `OFS_RELOAD, 32'h2, 32'h2);
      repeat (112) @(posedge clk);
      rd_chk("reload landed", `OFS_STATUS, 32'h0);
      wr_reg(`OFS_KEY, 32'hCCCC);
      wr_reg(`OFS_KEY, 32'hAAAA);
      repeat (96) @(posedge clk);
      #1;
      `CHK("reset early", 1'b0, wrst)
      repeat (64) @(posedge clk);
      #1;
      `CHK("reset at zero", 1'b1, wrst)
      `CHK("no irq at zero", 1'b0, irq)
      pulse_reset();
      `CHK("reset cleared", 1'b0, wrst)
      $display("test reset done");
      tally_and_finish();
   end
endmodule : watchdog_update_status_tb
bind wdg_update_status wdg_update_status_chk chk (.REF_CLK(REF_CLK), .SRST(SRST),
   .LOW_SPEED_OSC(LOW_SPEED_OSC), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .WDG_IRQ(WDG_IRQ), .WDG_RESET(WDG_RESET));
